// >>> efc_frame_config.sv
// ethernet frame config: ahb-lite register file plus the transmit
// framing path (pad, fcs append, header skip, length and size checks).
// assumes the phy side takes one byte every cycle with no back-pressure.
//
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module efc_frame_config #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // transmit byte stream from the descriptor engine
    input wire logic tx_in_valid,
    input wire efc_pkg::efc_byte_t tx_in_byte,
    output logic tx_in_ready,
    // transmit byte stream toward the phy
    output logic phy_tx_valid,
    output efc_pkg::efc_byte_t phy_tx_byte,
    // statistics vector
    output logic tx_stat_valid,
    output efc_pkg::efc_tx_stat_t tx_stat,
    // configuration toward the receive side
    output efc_pkg::efc_frame_cfg_t frame_cfg,
    output logic [6:0] rx_buffer_size,
    output logic [10:0] rx_buffer_bytes,
    output logic [63:0] pattern_mask,
    output logic rx_crc_check
);

    // =========================================================
    // declarations
    typedef enum logic [1:0] {S_DATA, S_PAD, S_FCS} efc_tx_state_t;

    // bus phase capture
    logic wr_pend_ff;                 // write data phase is due
    logic rd_pend_ff;                 // read waits one cycle
    logic [ADDR_W-1:0] addr_ff;       // latched byte address
    logic [31:0] lane_ff;             // byte lanes of the access
    logic hreadyout_ff;
    logic [31:0] hrdata_ff;
    // register storage
    logic [6:0] rxbuf_ff;
    logic [63:0] pmm_ff;
    efc_pkg::efc_frame_cfg_t cfg_ff;
    logic [10:0] rxbytes_ff;
    logic crc_check_ff;
    // transmit engine
    efc_tx_state_t state_ff;
    efc_tx_state_t nxt_state;
    logic [15:0] pos_ff;              // bytes accepted in this frame
    logic [15:0] body_ff;             // bytes counted past the header
    logic [31:0] crc_ff;
    logic [1:0] fcs_idx_ff;
    logic tagged_ff;
    logic [15:0] ltype_ff;
    logic ready_ff;
    logic out_valid_ff;
    efc_pkg::efc_byte_t out_byte_ff;
    logic stat_valid_ff;
    efc_pkg::efc_tx_stat_t stat_ff;
    logic [15:0] out_cnt_ff;
    logic padded_ff;
    logic mism_ff;

    // combinational helpers
    logic addr_take;
    logic size_ok;
    logic [31:0] lane_sel;
    logic [31:0] wdat;
    logic [31:0] rd_word;
    logic [11:0] ofs;
    logic in_take;
    logic in_hdr;
    logic append;
    logic [15:0] pad_target;
    logic [15:0] body_next;
    logic [15:0] hdr_len;
    logic [15:0] payload;
    logic [15:0] max_len;
    logic final_byte;
    logic [31:0] rxbuf_img;           // size register after the alias op
    logic [31:0] cfg_img;             // config register after the alias op

    // =========================================================
    // helpers
    // one byte through the reflected crc-32
    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ efc_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    // alias operation on a register image, lanes already applied
    function automatic logic [31:0] alias_op(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input logic [31:0] lane,
                                             input logic [1:0] op);
        logic [31:0] r;
        r = old;
        unique case (op)
            efc_pkg::ALIAS_WRITE: r = (old & ~lane) | d;
            efc_pkg::ALIAS_CLEAR: r = old & ~d;
            efc_pkg::ALIAS_SET: r = old | d;
            efc_pkg::ALIAS_INVERT: r = old ^ d;
        endcase
        return r;
    endfunction : alias_op

    // =========================================================
    // bus address phase
    assign addr_take = hsel & htrans[1] & hready;
    assign size_ok = (hsize == 3'h2) | (hsize == 3'h1);
    assign lane_sel = (hsize == 3'h2) ? 32'hFFFFFFFF :
                      (haddr[1] ? 32'hFFFF0000 : 32'h0000FFFF);
    assign wdat = hwdata & lane_ff;
    assign ofs = {{(12-ADDR_W){1'b0}}, addr_ff} & 12'hFF0;
    // register images after the alias op; fields are cut out below
    assign rxbuf_img = alias_op({21'h000000, rxbuf_ff, 4'h0}, wdat, lane_ff,
                                addr_ff[3:2]);
    assign cfg_img = alias_op({24'h000000, cfg_ff}, wdat, lane_ff,
                              addr_ff[3:2]);

    // capture the request; byte writes never become pending
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff <= '0;
            lane_ff <= 32'h00000000;
        end else begin
            wr_pend_ff <= addr_take & hwrite & size_ok;
            rd_pend_ff <= addr_take & ~hwrite;
            if (addr_take) begin
                addr_ff <= haddr[ADDR_W-1:0];
                lane_ff <= size_ok ? lane_sel : 32'h00000000;
            end
        end
    end

    // reads take one wait state so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
        end else begin
            hreadyout_ff <= ~(addr_take & ~hwrite);
        end
    end

    // read image of the addressed register, any alias reads the base
    always_comb begin
        rd_word = 32'h00000000;
        unique case (ofs)
            efc_pkg::RX_BUFFER_SIZE_CTRL_OFS:
                rd_word[10:4] = rxbuf_ff;
            efc_pkg::PATTERN_MASK_LOW_OFS: rd_word = pmm_ff[31:0];
            efc_pkg::PATTERN_MASK_HIGH_OFS: rd_word = pmm_ff[63:32];
            efc_pkg::MAC_FRAMING_CONFIG_OFS: rd_word[7:0] = cfg_ff;
            default: rd_word = 32'h00000000;
        endcase
    end

    // read data lands with hreadyout; unmapped or byte reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h00000000;
        end else if (rd_pend_ff) begin
            hrdata_ff <= (lane_ff == 32'h00000000) ? 32'h00000000 : rd_word;
        end
    end

    // =========================================================
    // register writes, applied at the end of the data phase
    // size field storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxbuf_ff <= efc_pkg::RX_BUFFER_SIZE_RST;
        end else if (wr_pend_ff &&
                     ofs == efc_pkg::RX_BUFFER_SIZE_CTRL_OFS) begin
            rxbuf_ff <= rxbuf_img[10:4];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pmm_ff <= {efc_pkg::PATTERN_MASK_RST, efc_pkg::PATTERN_MASK_RST};
        end else if (wr_pend_ff) begin
            if (ofs == efc_pkg::PATTERN_MASK_LOW_OFS) begin
                pmm_ff[31:0] <= alias_op(pmm_ff[31:0], wdat, lane_ff,
                                         addr_ff[3:2]);
            end
            if (ofs == efc_pkg::PATTERN_MASK_HIGH_OFS) begin
                pmm_ff[63:32] <= alias_op(pmm_ff[63:32], wdat, lane_ff,
                                          addr_ff[3:2]);
            end
        end
    end

    // framing options; a change mid-frame takes effect at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff <= efc_pkg::FRAMING_CONFIG_RST;
        end else if (wr_pend_ff &&
                     ofs == efc_pkg::MAC_FRAMING_CONFIG_OFS) begin
            cfg_ff <= cfg_img[7:0];
        end
    end

    // receive side views, one cycle behind the register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxbytes_ff <= 11'h000;
            crc_check_ff <= 1'b1;
        end else begin
            rxbytes_ff <= {rxbuf_ff, 4'h0};
            crc_check_ff <= ~cfg_ff.short_frame_pad_enable;
        end
    end

    // =========================================================
    // transmit framing decisions
    assign in_take = tx_in_valid & ready_ff;
    assign in_hdr = cfg_ff.crc_header_skip &
                    (pos_ff < efc_pkg::HEADER_SKIP_BYTES);
    assign append = cfg_ff.crc_append_enable |
                    cfg_ff.short_frame_pad_enable;
    assign body_next = body_ff + 16'h0001;

    // pad target by mode; zero means no padding
    always_comb begin
        pad_target = 16'h0000;
        if (cfg_ff.short_frame_pad_enable) begin
            if (cfg_ff.tagged_pad_enable) begin
                pad_target = efc_pkg::PAD_MIN_TAGGED;
            end else if (cfg_ff.automatic_pad_detect) begin
                pad_target = tagged_ff ? efc_pkg::PAD_MIN_TAGGED :
                                         efc_pkg::PAD_MIN_PLAIN;
            end else begin
                pad_target = efc_pkg::PAD_MIN_PLAIN;
            end
        end
    end

    // next state of the transmit path
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            S_DATA: begin
                if (in_take && tx_in_byte.last) begin
                    if (!in_hdr && body_next < pad_target) begin
                        nxt_state = S_PAD;
                    end else if (append) begin
                        nxt_state = S_FCS;
                    end
                end
            end
            S_PAD: begin
                if (body_next >= pad_target) begin
                    nxt_state = append ? S_FCS : S_DATA;
                end
            end
            S_FCS: begin
                if (fcs_idx_ff == 2'h3) begin
                    nxt_state = S_DATA;
                end
            end
        endcase
    end

    // state and input ready; input stalls during pad and fcs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= S_DATA;
            ready_ff <= 1'b0;
            fcs_idx_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            ready_ff <= (nxt_state == S_DATA) &&
                        !(in_take && tx_in_byte.last);
            fcs_idx_ff <= (state_ff == S_FCS) ? fcs_idx_ff + 2'h1 : 2'h0;
        end
    end

    // byte counters; counters restart once the frame's last byte leaves
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_ff <= 16'h0000;
            body_ff <= 16'h0000;
        end else if (final_byte) begin
            pos_ff <= 16'h0000;
            body_ff <= 16'h0000;
        end else if (in_take) begin
            pos_ff <= pos_ff + 16'h0001;
            if (!in_hdr) begin
                body_ff <= body_next;
            end
        end else if (state_ff == S_PAD) begin
            body_ff <= body_next;
        end
    end

    // fcs over body and pad bytes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc_ff <= efc_pkg::CRC_INIT;
        end else if (final_byte) begin
            crc_ff <= efc_pkg::CRC_INIT;
        end else if (in_take && !in_hdr) begin
            crc_ff <= crc_byte(crc_ff, tx_in_byte.data);
        end else if (state_ff == S_PAD) begin
            crc_ff <= crc_byte(crc_ff, 8'h00);
        end
    end

    // tag and length/type field capture from the body bytes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tagged_ff <= 1'b0;
            ltype_ff <= 16'h0000;
        end else if (final_byte) begin
            tagged_ff <= 1'b0;
            ltype_ff <= 16'h0000;
        end else if (in_take && !in_hdr) begin
            if (body_ff == efc_pkg::TYPE_POS ||
                (tagged_ff && body_ff == efc_pkg::TAGGED_TYPE_POS)) begin
                ltype_ff[15:8] <= tx_in_byte.data;
            end
            if (body_ff == efc_pkg::TYPE_POS + 16'h0001 ||
                (tagged_ff &&
                 body_ff == efc_pkg::TAGGED_TYPE_POS + 16'h0001)) begin
                ltype_ff[7:0] <= tx_in_byte.data;
                tagged_ff <= tagged_ff |
                    ((body_ff == efc_pkg::TYPE_POS + 16'h0001) &&
                     ltype_ff[15:8] == efc_pkg::VLAN_TPID_HI &&
                     tx_in_byte.data == efc_pkg::VLAN_TPID_LO);
            end
        end
    end

    // =========================================================
    // output stream and statistics
    assign final_byte = (state_ff == S_FCS && fcs_idx_ff == 2'h3) ||
                        (state_ff == S_PAD && nxt_state == S_DATA) ||
                        (state_ff == S_DATA && in_take &&
                         tx_in_byte.last && nxt_state == S_DATA);

    // output byte register, one byte per cycle to the phy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_valid_ff <= 1'b0;
            out_byte_ff <= '0;
        end else begin
            out_valid_ff <= in_take || (state_ff != S_DATA);
            out_byte_ff.last <= final_byte;
            unique case (state_ff)
                S_DATA: out_byte_ff.data <= tx_in_byte.data;
                S_PAD: out_byte_ff.data <= 8'h00;
                S_FCS: out_byte_ff.data <= ~crc_ff[8*fcs_idx_ff +: 8];
            endcase
        end
    end

    // length/type check operands; short frames are checked before their pad bytes
    assign hdr_len = efc_pkg::MAC_HEADER_BYTES +
                     (tagged_ff ? efc_pkg::VLAN_TAG_BYTES : 16'h0000);
    assign max_len = tagged_ff ? efc_pkg::MAX_FRAME_TAGGED :
                                 efc_pkg::MAX_FRAME_PLAIN;
    assign payload = body_next - hdr_len -
                     (append ? 16'h0000 : efc_pkg::FCS_BYTES);

    // frame totals, counted up to the frame's last byte; mismatch latched when the last input byte is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_cnt_ff <= 16'h0000;
            padded_ff <= 1'b0;
            mism_ff <= 1'b0;
        end else if (final_byte) begin
            out_cnt_ff <= 16'h0000;
            padded_ff <= 1'b0;
            mism_ff <= 1'b0;
        end else begin
            if (in_take || state_ff != S_DATA) begin
                out_cnt_ff <= out_cnt_ff + 16'h0001;
            end
            if (state_ff == S_PAD) begin
                padded_ff <= 1'b1;
            end
            if (in_take && tx_in_byte.last) begin
                mism_ff <= cfg_ff.frame_length_check &&
                           ltype_ff <= efc_pkg::MAX_LENGTH_FIELD &&
                           payload != ltype_ff;
            end
        end
    end

    // statistics vector, a pulse with the frame's last byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_valid_ff <= 1'b0;
            stat_ff <= '0;
        end else begin
            stat_valid_ff <= final_byte;
            if (final_byte) begin
                stat_ff.byte_count <= out_cnt_ff + 16'h0001;
                stat_ff.padded <= padded_ff | (state_ff == S_PAD);
                stat_ff.crc_appended <= append;
                stat_ff.length_mismatch <= mism_ff |
                    (state_ff == S_DATA && cfg_ff.frame_length_check &&
                     ltype_ff <= efc_pkg::MAX_LENGTH_FIELD &&
                     payload != ltype_ff);
                stat_ff.oversize <= !cfg_ff.oversize_frame_enable &&
                    (body_next + (state_ff == S_FCS ? 16'h0000 :
                     (append ? efc_pkg::FCS_BYTES : 16'h0000))) > max_len;
            end
        end
    end

    // =========================================================
    // outputs, each straight from a flip-flop except hresp, tied low
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign tx_in_ready = ready_ff;
    assign phy_tx_valid = out_valid_ff;
    assign phy_tx_byte = out_byte_ff;
    assign tx_stat_valid = stat_valid_ff;
    assign tx_stat = stat_ff;
    assign frame_cfg = cfg_ff;
    assign rx_buffer_size = rxbuf_ff;
    assign rx_buffer_bytes = rxbytes_ff;
    assign pattern_mask = pmm_ff;
    assign rx_crc_check = crc_check_ff;

endmodule : efc_frame_config
`default_nettype wire

// >>> efc_phy_sink.sv
// phy model: sinks every transmit byte and runs the fcs over all but the skipped header bytes
// assumes one byte per clock, no back-pressure toward the mac
`timescale 1ns/10ps
`default_nettype none
module efc_phy_sink (
    // link from the mac
    input wire logic hclk,
    input wire logic phy_tx_valid,
    input wire efc_pkg::efc_byte_t phy_tx_byte,
    input wire logic hdr_skip,
    // per-frame results
    output logic [31:0] residue,
    output int frame_len,
    output int frames
);
    logic [31:0] c = 32'hFFFFFFFF;
    int n = 0;
    initial frames = 0;
    // reflected crc, fcs included so a good frame leaves the residue
    always @(posedge hclk) begin
        if (phy_tx_valid) begin
            // leading header bytes stay out of the crc
            if (!hdr_skip || n > 3) begin
                c = c ^ {24'h0, phy_tx_byte.data};
                for (int i = 0; i < 8; i++)
                    c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
            end
            n = n + 1;
            if (phy_tx_byte.last) begin
                residue <= c;
                frame_len <= n;
                frames <= frames + 1;
                c = 32'hFFFFFFFF;
                n = 0;
            end
        end
    end
endmodule : efc_phy_sink
`default_nettype wire

// >>> efc_pkg.sv
// constants, field layouts and carrier types of the ethernet frame config
// block; assumes one 50 MHz bus clock domain and an AHB-Lite master.
package efc_pkg;

    // =========================================================
    // register map, each register with clear, set, invert alias
    localparam logic [11:0] RX_BUFFER_SIZE_CTRL_OFS = 12'h000;
    localparam logic [11:0] PATTERN_MASK_LOW_OFS = 12'h010;
    localparam logic [11:0] PATTERN_MASK_HIGH_OFS = 12'h020;
    localparam logic [11:0] MAC_FRAMING_CONFIG_OFS = 12'h030;
    localparam logic [1:0] ALIAS_WRITE = 2'h0;
    localparam logic [1:0] ALIAS_CLEAR = 2'h1;
    localparam logic [1:0] ALIAS_SET = 2'h2;
    localparam logic [1:0] ALIAS_INVERT = 2'h3;

    // =========================================================
    // field positions and reset values
    localparam int RX_BUFFER_SIZE_LSB = 4;
    localparam int RX_BUFFER_SIZE_W = 7;
    localparam int RX_BUFFER_UNIT_SHIFT = 4;
    localparam logic [6:0] RX_BUFFER_SIZE_RST = 7'h00;
    localparam logic [31:0] PATTERN_MASK_RST = 32'h00000000;
    localparam logic [7:0] FRAMING_CONFIG_RST = 8'h00;

    // =========================================================
    // frame geometry, in bytes
    localparam logic [15:0] PAD_MIN_PLAIN = 16'h003C;
    localparam logic [15:0] PAD_MIN_TAGGED = 16'h0040;
    localparam logic [15:0] MAX_FRAME_PLAIN = 16'h05EE;
    localparam logic [15:0] MAX_FRAME_TAGGED = 16'h05F2;
    localparam logic [15:0] MAX_LENGTH_FIELD = 16'h05DC;
    localparam logic [15:0] HEADER_SKIP_BYTES = 16'h0004;
    localparam logic [15:0] MAC_HEADER_BYTES = 16'h000E;
    localparam logic [15:0] VLAN_TAG_BYTES = 16'h0004;
    localparam logic [15:0] FCS_BYTES = 16'h0004;
    localparam logic [15:0] TYPE_POS = 16'h000C;
    localparam logic [15:0] TAGGED_TYPE_POS = 16'h0010;
    localparam logic [7:0] VLAN_TPID_HI = 8'h81;
    localparam logic [7:0] VLAN_TPID_LO = 8'h00;

    // =========================================================
    // fcs polynomial, reflected form
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

    // framing options, bit order as in the config register
    typedef struct packed {
        logic automatic_pad_detect;
        logic tagged_pad_enable;
        logic short_frame_pad_enable;
        logic crc_append_enable;
        logic crc_header_skip;
        logic oversize_frame_enable;
        logic frame_length_check;
        logic full_duplex_select;
    } efc_frame_cfg_t;

    // one byte of a frame stream
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } efc_byte_t;

    // transmit statistics vector
    typedef struct packed {
        logic [15:0] byte_count;
        logic padded;
        logic crc_appended;
        logic length_mismatch;
        logic oversize;
    } efc_tx_stat_t;

endpackage : efc_pkg

// >>> efc_properties.sv
// port-level assertions for the frame config block
// bound to every instance of the top module
`timescale 1ns/10ps
`default_nettype none
module efc_properties (
    // bus side
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // stream and config side
    input wire logic tx_in_valid,
    input wire efc_pkg::efc_byte_t tx_in_byte,
    input wire logic tx_in_ready,
    input wire logic phy_tx_valid,
    input wire efc_pkg::efc_byte_t phy_tx_byte,
    input wire logic tx_stat_valid,
    input wire efc_pkg::efc_tx_stat_t tx_stat,
    input wire efc_pkg::efc_frame_cfg_t frame_cfg,
    input wire logic [6:0] rx_buffer_size,
    input wire logic [10:0] rx_buffer_bytes,
    input wire logic rx_crc_check
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_buf_bytes: assert property (
        rx_buffer_bytes == {$past(rx_buffer_size), 4'h0}) else $error("bytes");
    a_crc_check: assert property (
        rx_crc_check == !$past(frame_cfg.short_frame_pad_enable))
        else $error("crc check");
    a_bus_okay: assert property (hresp == 1'b0) else $error("resp");
    a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait");
    a_phy_follow: assert property (tx_in_valid && tx_in_ready
        |=> phy_tx_valid && phy_tx_byte.data == $past(tx_in_byte.data))
        else $error("phy byte");
    a_ready_drop: assert property (tx_in_valid && tx_in_ready &&
        tx_in_byte.last |=> !tx_in_ready) else $error("ready");
    a_stat_last: assert property (tx_stat_valid
        |-> phy_tx_valid && phy_tx_byte.last) else $error("stat");
    a_fcs_added: assert property (tx_stat_valid &&
        (frame_cfg.crc_append_enable || frame_cfg.short_frame_pad_enable)
        |-> tx_stat.crc_appended) else $error("fcs");
    c_read: cover property (hsel && htrans[1] && !hwrite);
    c_pad: cover property (tx_stat_valid && tx_stat.padded);
    c_tag: cover property (tx_stat_valid && frame_cfg.tagged_pad_enable);
endmodule : efc_properties
bind efc_frame_config efc_properties i_efc_properties (.*);
`default_nettype wire

// >>> tb_efc_frame_config.sv
// self-checking bench: registers over ahb-lite, frames into the phy model
// assumes the single slave's hreadyout is the bus hready
`timescale 1ns/10ps
`default_nettype none
module tb_efc_frame_config;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, residue;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, tx_in_valid = 1'b0, tx_in_ready, phy_tx_valid;
    logic tx_stat_valid, rx_crc_check;
    logic [6:0] rx_buffer_size;
    logic [10:0] rx_buffer_bytes;
    logic [63:0] pattern_mask;
    efc_pkg::efc_byte_t tx_in_byte = '0, phy_tx_byte;
    efc_pkg::efc_tx_stat_t tx_stat;
    efc_pkg::efc_frame_cfg_t frame_cfg;
    int n_fail = 0, check_count = 0, frame_len, frames;
    initial forever #10 hclk = ~hclk;
    efc_frame_config i_efc_frame_config (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .tx_in_valid, .tx_in_byte, .tx_in_ready,
        .phy_tx_valid, .phy_tx_byte, .tx_stat_valid, .tx_stat, .frame_cfg,
        .rx_buffer_size, .rx_buffer_bytes, .pattern_mask, .rx_crc_check);
    efc_phy_sink i_efc_phy_sink (.hclk, .phy_tx_valid, .phy_tx_byte,
        .hdr_skip(frame_cfg.crc_header_skip), .residue, .frame_len, .frames);
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one single transfer; holds each phase until hready is sampled high
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [2:0] sz, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic test_regs;
        ahb(0, 32'h30, 3'h2, 32'h0); chk(rd, 32'h0);
        // receive is never enabled here, so size writes are legal
        ahb(1, 32'h0, 3'h2, 32'hFFFFFFFF);
        ahb(0, 32'h0, 3'h2, 32'h0); chk(rd, 32'h7F0);
        chk(rx_buffer_bytes, 11'h7F0);
        ahb(1, 32'h4, 3'h2, 32'h7F0);
        @(posedge hclk);
        chk(rx_buffer_size, 7'h00);
        // matching stays idle, so mask writes are legal
        ahb(1, 32'h12, 3'h1, 32'hABCD0000);
        ahb(1, 32'h10, 3'h0, 32'hFFFFFFFF); // byte write, dropped
        ahb(1, 32'h20, 3'h2, 32'h87000000);
        @(posedge hclk);
        chk(pattern_mask, 64'h87000000ABCD0000);
        ahb(0, 32'hF0, 3'h2, 32'h0); chk(rd, 32'h0);
    endtask : test_regs
    // every padding entry also carries the crc bit
    task automatic test_frames;
        logic [7:0] cfg [8] = '{8'h10, 8'h30, 8'h70, 8'h00, 8'h50, 8'hB0,
                                8'hB0, 8'h38};
        int len [8] = '{18, 64, 68, 14, 18, 64, 68, 68};
        logic [7:0] d;
        int n;
        for (int k = 0; k < 8; k++) begin
            ahb(1, 32'h30, 3'h2, {24'h0, cfg[k]});
            n = frames;
            for (int i = 0; i < 14; i++) begin
                d = i[7:0];
                if (k == 6 && i > 11) d = (i == 12) ? 8'h81 : 8'h00;
                tx_in_valid <= 1'b1;
                tx_in_byte <= '{d, i == 13};
                do @(posedge hclk); while (tx_in_ready !== 1'b1);
            end
            tx_in_valid <= 1'b0;
            for (int t = 0; t < 200 && frames == n; t++) @(posedge hclk);
            @(posedge hclk);
            chk(frame_len, len[k]);
            chk(frames, n + 1);
            chk(tx_stat.byte_count, len[k]);
            chk(tx_stat.crc_appended, cfg[k][4] | cfg[k][5]);
            chk(frame_cfg, cfg[k]);
            chk(tx_stat.padded, len[k] > 18);
            if (cfg[k][4]) chk(residue, 32'hDEBB20E3);
            chk(rx_crc_check, !cfg[k][5]);
        end
    endtask : test_frames
    task automatic tally_and_finish;
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_regs();
        test_frames();
        tally_and_finish();
    end
endmodule : tb_efc_frame_config
`default_nettype wire
